// >>> src/csx_exec.sv
// execution of compare-skip-greater, compare-skip-less, decimal adjust
// assumes fetch logic supplies the instruction at q1 and a flag telling
// whether the next fetched instruction is two words long
//
// Summary of operation
// - decode skip-if-greater: 0110 010a ffff ffff, a is bank access bit.
// - decode skip-if-less: 0110 000a ffff ffff, a is bank access bit.
// - compare data byte and accumulator unsigned; flags untouched.
// - skip-greater discards next instruction when byte exceeds accumulator.
// - skip-less discards next instruction when byte below accumulator.
// - access bit clear uses access bank; set uses bank select register.
// - access clear and extended set: address up to 5Fh is indexed.
// - compare takes one cycle, two when skipping, three over 2-word.
// - quarters: decode, read byte, compare, no write in fourth.
// - adjust adds six to low nibble if above nine or digit carry.
// - high nibble adds carry-in, then six if above nine or carry.
// - adjust has no operands, one word, one cycle, packed BCD result.
`timescale 1ns/1ns
module csx_exec
   import csx_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [15:0] INSTR,
   input wire logic INSTR_VALID,
   input wire logic NEXT_IS_TWO_WORD,
   input wire logic [3:0] BANK_SELECT_REGISTER,
   input wire logic EXTENDED_SET,
   input wire logic [11:0] INDEX_BASE,
   input wire logic [7:0] MEM_RDATA,
   input wire logic [7:0] WORKING_ACCUMULATOR,
   input wire logic DIGIT_CARRY_FLAG,
   input wire logic CARRY_FLAG,
   output logic [1:0] QUARTER,
   output logic [11:0] MEM_ADDR,
   output logic MEM_RD,
   output logic [7:0] ACC_WDATA,
   output logic ACC_WE,
   output logic CARRY_WDATA,
   output logic CARRY_WE,
   output logic SKIP_ACTIVE,
   output logic BUSY
);
   csx_quarter_e q_r;
   logic is_gt_r, is_lt_r, is_daw_r, two_word_r;
   logic [1:0] skip_left_r;
   logic [11:0] addr_r;
   logic rd_r;
   logic [7:0] acc_w_r;
   logic acc_we_r, c_w_r, c_we_r;
   logic [7:0] adj_result;
   logic adj_carry;
   logic [11:0] addr_nxt;
   logic take_skip;

   ////////////////////////////////////////////////////////////////////////
   // quarter sequencer, free running four-phase counter
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         q_r <= Q1;
      end else begin
         case (q_r)
            Q1: q_r <= Q2;
            Q2: q_r <= Q3;
            Q3: q_r <= Q4;
            Q4: q_r <= Q1;
            default: q_r <= Q1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand address: access bank, banked, or indexed literal offset
   always_comb begin
      if (INSTR[ACCESS_BIT]) begin
         addr_nxt = {BANK_SELECT_REGISTER, INSTR[ADDR_HI:0]};
      end else if (INSTR[ADDR_HI]) begin
         addr_nxt = {SFR_BANK, INSTR[ADDR_HI:0]};
      end else begin
         addr_nxt = {ZERO_BANK, INSTR[ADDR_HI:0]};
      end
      if (!INSTR[ACCESS_BIT] && EXTENDED_SET &&
          INSTR[ADDR_HI:0] <= INDEXED_LIMIT) begin
         addr_nxt = INDEX_BASE + {4'h0, INSTR[ADDR_HI:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode in q1; a skipped slot decodes nothing
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         is_gt_r <= 1'b0;
         is_lt_r <= 1'b0;
         is_daw_r <= 1'b0;
         two_word_r <= 1'b0;
         addr_r <= ADDR_ZERO;
      end else if (q_r == Q1) begin
         is_gt_r <= INSTR_VALID && skip_left_r == SKIP_NONE &&
                    INSTR[OPC_HI:OPC_LO] == OP_SKIP_GREATER;
         is_lt_r <= INSTR_VALID && skip_left_r == SKIP_NONE &&
                    INSTR[OPC_HI:OPC_LO] == OP_SKIP_LESS;
         is_daw_r <= INSTR_VALID && skip_left_r == SKIP_NONE &&
                     INSTR == OP_DECIMAL_ADJUST;
         two_word_r <= NEXT_IS_TWO_WORD;
         addr_r <= addr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data byte in q2 only
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_r <= 1'b0;
      end else begin
         // strobe drops after one cycle unless a new compare is decoded
         rd_r <= 1'b0;
         if (q_r == Q1) begin
            rd_r <= INSTR_VALID && skip_left_r == SKIP_NONE &&
                    (INSTR[OPC_HI:OPC_LO] == OP_SKIP_GREATER ||
                     INSTR[OPC_HI:OPC_LO] == OP_SKIP_LESS);
         end
      end
   end

   always_comb begin
      take_skip = (is_gt_r && MEM_RDATA > WORKING_ACCUMULATOR) ||
                  (is_lt_r && MEM_RDATA < WORKING_ACCUMULATOR);
   end

   ////////////////////////////////////////////////////////////////////////
   // skip counter: slots of forced no-operation still to come
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         skip_left_r <= SKIP_NONE;
      end else if (q_r == Q3 && take_skip) begin
         skip_left_r <= two_word_r ? SKIP_TWO : SKIP_ONE;
      end else if (q_r == Q4 && skip_left_r != SKIP_NONE &&
                   !is_gt_r && !is_lt_r) begin
         skip_left_r <= skip_left_r - SKIP_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   csx_bcd_adjust u_adjust (
      .acc(WORKING_ACCUMULATOR),
      .digit_carry(DIGIT_CARRY_FLAG),
      .carry(CARRY_FLAG),
      .result(adj_result),
      .carry_out(adj_carry)
   );

   // adjust write in q4, accumulator and carry
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         acc_w_r <= BYTE_ZERO;
         acc_we_r <= 1'b0;
         c_w_r <= 1'b0;
         c_we_r <= 1'b0;
      end else begin
         // compare writes nothing in fourth quarter
         acc_we_r <= (q_r == Q3) && is_daw_r;
         c_we_r <= (q_r == Q3) && is_daw_r;
         if (q_r == Q3 && is_daw_r) begin
            acc_w_r <= adj_result;
            c_w_r <= adj_carry;
         end
      end
   end

   // registered status outputs
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         MEM_ADDR <= ADDR_ZERO;
         QUARTER <= 2'h0;
         SKIP_ACTIVE <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         MEM_ADDR <= (q_r == Q1) ? addr_nxt : addr_r;
         QUARTER <= q_r + 2'h1;
         SKIP_ACTIVE <= skip_left_r != SKIP_NONE;
         BUSY <= is_gt_r || is_lt_r || is_daw_r;
      end
   end

   assign MEM_RD = rd_r;
   assign ACC_WDATA = acc_w_r;
   assign ACC_WE = acc_we_r;
   assign CARRY_WDATA = c_w_r;
   assign CARRY_WE = c_we_r;
endmodule

// >>> src/csx_pkg.sv
// package for the compare-skip and decimal adjust execution block
// assumes a core that splits each instruction cycle into four quarters
package csx_pkg;
   // opcode patterns, upper seven bits of the instruction word; decimal adjust is the whole word
   localparam logic [6:0] OP_SKIP_GREATER = 7'h32;
   localparam logic [6:0] OP_SKIP_LESS = 7'h30;
   localparam logic [15:0] OP_DECIMAL_ADJUST = 16'h0007;
   // field positions
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 9;
   localparam int ACCESS_BIT = 8;
   localparam int ADDR_HI = 7;
   // indexed literal offset limit, inclusive
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   // access bank upper half is the special function area at bank 15
   localparam logic [3:0] SFR_BANK = 4'hF;
   localparam logic [3:0] ZERO_BANK = 4'h0;
   // decimal adjust constants, zero values and skip counts
   localparam logic [4:0] BCD_MAX = 5'h09;
   localparam logic [4:0] BCD_FIX = 5'h06;
   localparam logic [4:0] NIB_ZERO = 5'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [11:0] ADDR_ZERO = 12'h000;
   localparam logic [1:0] SKIP_ONE = 2'h1;
   localparam logic [1:0] SKIP_TWO = 2'h2;
   localparam logic [1:0] SKIP_NONE = 2'h0;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} csx_quarter_e;
endpackage

// >>> src/csx_bcd_adjust.sv
// decimal adjust datapath, purely combinational
// assumes accumulator and flags are stable for the whole cycle
`timescale 1ns/1ns
module csx_bcd_adjust
   import csx_pkg::*;
(
   input wire logic [7:0] acc,
   input wire logic digit_carry,
   input wire logic carry,
   output logic [7:0] result,
   output logic carry_out
);
   logic [4:0] lo_sum;
   logic [4:0] hi_in;
   logic [4:0] hi_sum;
   logic dc_lo;

   // nibble corrections; low carry ripples into the high nibble
   always_comb begin
      lo_sum = {1'b0, acc[3:0]};
      if (lo_sum > BCD_MAX || digit_carry) begin
         lo_sum = lo_sum + BCD_FIX;
      end
      dc_lo = lo_sum[4];
      hi_in = {1'b0, acc[7:4]} + {4'h0, dc_lo};
      if (hi_in > BCD_MAX || carry) begin
         hi_sum = hi_in + BCD_FIX;
      end else begin
         hi_sum = hi_in;
      end
      result = {hi_sum[3:0], lo_sum[3:0]};
      carry_out = hi_sum[4] | carry;
   end
endmodule

// >>> tb/csx_exec_asserts.sv
// checker for the compare-skip and decimal adjust block
// assumes it is bound to csx_exec and sees only its ports
`timescale 1ns/1ns
module csx_exec_asserts (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [1:0] QUARTER,
   input wire logic MEM_RD,
   input wire logic ACC_WE,
   input wire logic CARRY_WE,
   input wire logic SKIP_ACTIVE
);
   logic [3:0] run_r;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////
   // length of a skip run: the compare's own q4 plus one or two slots,
   // so a run past nine cycles means a stuck skip
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N)
         run_r <= 4'h0;
      else
         run_r <= SKIP_ACTIVE ? run_r + 4'h1 : 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // quarters advance
   property p_q_step;
      RESET_N |=> QUARTER == $past(QUARTER) + 2'h1;
   endproperty
   a_q_step: assert property (p_q_step) else $error("quarter stuck");
   property p_we_pair; ACC_WE == CARRY_WE; endproperty
   a_we_pair: assert property (p_we_pair) else $error("we split");
   property p_we_pulse; ACC_WE |=> !ACC_WE; endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("we long");
   property p_rd_pulse; MEM_RD |=> !MEM_RD; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("rd long");
   property p_rd_nowr; MEM_RD |-> ##1 !ACC_WE ##1 !ACC_WE; endproperty
   a_rd_nowr: assert property (p_rd_nowr) else $error("write");
   property p_skip_src; $rose(SKIP_ACTIVE) |-> $past(MEM_RD, 3); endproperty
   a_skip_src: assert property (p_skip_src) else $error("no read");
   property p_skip_min; $rose(SKIP_ACTIVE) |-> SKIP_ACTIVE[*5]; endproperty
   a_skip_min: assert property (p_skip_min) else $error("short");
   property p_skip_max; run_r <= 4'h9; endproperty
   a_skip_max: assert property (p_skip_max) else $error("long");
   property p_we_nosk; ACC_WE |-> !SKIP_ACTIVE; endproperty
   a_we_nosk: assert property (p_we_nosk) else $error("skip wr");
   c_skip: cover property ($rose(SKIP_ACTIVE));
   c_two: cover property (run_r == 4'h9);
   c_adj: cover property (ACC_WE);
endmodule
bind csx_exec csx_exec_asserts csx_exec_asserts_i (.CLOCK(CLOCK),
   .RESET_N(RESET_N), .QUARTER(QUARTER), .MEM_RD(MEM_RD),
   .ACC_WE(ACC_WE), .CARRY_WE(CARRY_WE), .SKIP_ACTIVE(SKIP_ACTIVE));

// >>> tb/testbench.sv
// random bench for the compare-skip and decimal adjust block
// assumes one instruction per 16 clocks, idle words in between
`timescale 1ns/1ns
module testbench;
   import csx_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
   logic clk = 0, rst_n = 0, vld = 0, two = 0, ext = 0, dc = 0, cy = 0;
   logic [15:0] ins = 16'h0000;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] ib = 12'h000;
   logic [7:0] md = 8'h00, w = 8'h00, lf = 8'h1a;
   logic [11:0] ma;
   logic [7:0] aw;
   logic mr, ae, ce, sk, bz;
   int n_mismatch = 0, num_checks = 0;
   always #50 clk = ~clk;
   csx_exec csx_exec_i (.CLOCK(clk), .RESET_N(rst_n), .INSTR(ins),
      .INSTR_VALID(vld), .NEXT_IS_TWO_WORD(two), .BANK_SELECT_REGISTER(bank_select_register),
      .EXTENDED_SET(ext), .INDEX_BASE(ib), .MEM_RDATA(md),
      .WORKING_ACCUMULATOR(w), .DIGIT_CARRY_FLAG(dc), .CARRY_FLAG(cy),
      .QUARTER(), .MEM_ADDR(ma), .MEM_RD(mr), .ACC_WDATA(aw), .ACC_WE(ae),
      .CARRY_WDATA(ce), .CARRY_WE(), .SKIP_ACTIVE(sk), .BUSY(bz));
   ////////////////////////////////////////////////////////////////////////
   // random source and expected values
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [8:0] adj(input logic [7:0] a, input logic d, c);
      logic [4:0] lo, hi;
      // the low nibble fix carries into the high nibble
      lo = {1'b0, a[3:0]};
      if (lo > BCD_MAX || d) lo = lo + BCD_FIX;
      hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
      if (hi > BCD_MAX || c) hi = hi + BCD_FIX;
      return {c | hi[4], hi[3:0], lo[3:0]};
   endfunction
   function automatic logic [11:0] adr(input logic a, input logic [7:0] f);
      if (a) return {bank_select_register, f};
      if (ext && f <= INDEXED_LIMIT) return ib + {4'h0, f};
      return {f[7] ? SFR_BANK : ZERO_BANK, f};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one instruction, then idle slots so a two-word skip fits the window
   task automatic run(input logic [1:0] op, input logic a,
      input logic [7:0] f, d, x);
      int nr, nw, ns, nb;
      logic [11:0] ga;
      logic [8:0] gw;
      logic s;
      nr = 0;
      nw = 0;
      ns = 0;
      nb = 0;
      lf = nxt(lf);
      ins <= op == 2'd2 ? OP_DECIMAL_ADJUST :
         {op[0] ? OP_SKIP_LESS : OP_SKIP_GREATER, a, f};
      vld <= 1'b1;
      md <= d;
      w <= x;
      bank_select_register <= lf[3:0];
      ext <= lf[4];
      two <= lf[5];
      dc <= lf[6];
      cy <= lf[7];
      ib <= {lf, lf[3:0]};
      @(posedge clk);
      ins <= 16'h0000;
      vld <= 1'b0;
      repeat (15) begin
         @(negedge clk);
         if (mr) begin
            nr++;
            ga = ma;
         end
         if (ae) begin
            nw++;
            gw = {ce, aw};
         end
         ns += sk;
         nb += bz;
      end
      @(posedge clk);
      s = op == 2'd0 ? d > x : op == 2'd1 && d < x;
      `CHK(nr, op != 2'd2)
      if (op != 2'd2) `CHK(ga, adr(a, f))
      // skip level also covers the compare's own fourth quarter
      `CHK(ns, s ? (two ? 9 : 5) : 0)
      `CHK(nb, 4)
      `CHK(nw, op == 2'd2)
      if (op == 2'd2) `CHK(gw, adj(x, dc, cy))
      $display("test op %0d f %h done", op, f);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      run(2'd0, 1'b1, 8'h10, 8'h80, 8'h80);
      run(2'd1, 1'b0, 8'h5f, 8'h00, 8'h01);
      run(2'd0, 1'b0, 8'h60, 8'hff, 8'h00);
      run(2'd1, 1'b0, 8'h80, 8'h7f, 8'h80);
      run(2'd2, 1'b0, 8'h00, 8'h00, 8'h99);
      repeat (24) begin
         run(2'(lf % 3), lf[3], nxt(lf), lf ^ 8'h5a, nxt(nxt(lf)));
      end
      test_done();
   end
   // watchdog well past the expected run length
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end
endmodule
